// ==== logic/msc_pkg.sv ====
package msc_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int PROG_MIN_NS = 500;
    localparam int PROG_MIN_CYC =
        (PROG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CLEAR_CYC = 64;
    localparam int HALF_BASE = 4;
    localparam int CRC_BITS = 16;

    // ------------------------------------------------------------
    // Codes and reset values
    // ------------------------------------------------------------
    localparam logic [2:0] MODE_MASTER_SERIAL = 3'h0;
    localparam logic [15:0] CRC_POLY = 16'h1021;
    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    localparam logic [7:0] SYNC_RST = 8'h80;
    localparam logic [1:0] RATE_RST = 2'h0;
    localparam logic [31:0] LEN_RST = 32'h0000_0100;
    localparam logic [4:0] MASK_RST = 5'h00;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_LEN = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_INT_STAT = 8'h0C;
    localparam logic [7:0] ADDR_INT_MASK = 8'h10;
    localparam logic [7:0] ADDR_BITCNT = 8'h14;
    localparam int STAT_INIT_BIT = 3;
    localparam int STAT_DONE_BIT = 4;
    localparam int STAT_SEL_BIT = 5;
    localparam int STAT_MODE_LSB = 8;

    typedef enum logic [2:0] {
        ST_CLEAR, ST_WAIT_INIT, ST_LOAD, ST_CHECK,
        ST_PASS, ST_USER, ST_ERROR, ST_MODE_ERR
    } state_t;

    typedef struct packed {
        logic prog;
        logic sel_chg;
        logic mode_err;
        logic crc_err;
        logic done;
    } evt_t;

    typedef struct packed {
        logic prog_n;
        logic sel;
        logic [2:0] mode;
        logic din;
        logic init_n;
        logic done;
    } pins_t;

endpackage : msc_pkg

// ==== logic/cfg_clock_gen.sv ====
`timescale 1ns/1ns
module cfg_clock_gen import msc_pkg::*; #(
    parameter int CW = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic run,
    input wire logic [1:0] rate,
    output logic config_clock_out,
    output logic rise
);

    logic [CW-1:0] cnt_r;
    logic [CW-1:0] half;
    logic config_clock_out_r;

    assign half = CW'(HALF_BASE) << rate;
    assign config_clock_out = config_clock_out_r;
    assign rise = run && !config_clock_out_r && (cnt_r == half - CW'(1));

    // ------------------------------------------------------------
    // Divider: half period is HALF_BASE shifted by the rate option
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r <= '0;
            config_clock_out_r <= 1'b0;
        end else if (!run) begin
            cnt_r <= '0;
            config_clock_out_r <= 1'b0;
        end else if (cnt_r == half - CW'(1)) begin
            cnt_r <= '0;
            config_clock_out_r <= ~config_clock_out_r;
        end else begin
            cnt_r <= cnt_r + CW'(1);
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_rate;
        @(posedge clk) disable iff (rst)
        (run && $past(run) && $changed(config_clock_out_r))
            |-> ($past(cnt_r) == $past(half) - CW'(1));
    endproperty
    a_rate: assert property (p_rate)
        else $error("config clock toggled off its rate");

endmodule : cfg_clock_gen

// ==== logic/crc16_serial.sv ====
`timescale 1ns/1ns
module crc16_serial import msc_pkg::*; (
    input wire logic clk,
    input wire logic rst,
    input wire logic clear,
    input wire logic shift,
    input wire logic bit_in,
    output logic [15:0] crc
);

    logic [15:0] crc_r;
    logic fb;

    assign fb = crc_r[15] ^ bit_in;
    assign crc = crc_r;

    // ------------------------------------------------------------
    // Serial CRC, MSB first
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            crc_r <= CRC_INIT;
        end else if (clear) begin
            crc_r <= CRC_INIT;
        end else if (shift) begin
            crc_r <= {crc_r[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
        end
    end

endmodule : crc16_serial

// ==== logic/msc_port.sv ====
// Contract
// - Pull-ups on while configuring and select low
// - Dual-purpose pins released after done seen high
// - Pull-up select becomes user pin after done
// - Config clock from internal divider, rate option
// - Config clock driven to PROM during configuration
// - PROM serial data enters on serial input
// - Serial output actively driven throughout configuration
// - Serial output feeds next chained device input
// - Init held low while clearing, then released
// - Done low until successful configuration completes
// - Program low 500 ns restarts on release
// - CRC error drives init indicator low
`timescale 1ns/1ns
module msc_port import msc_pkg::*; #(
    parameter int CLEAR_LEN = CLEAR_CYC
) (
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic [7:0] PADDR,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic IRQ,
    input wire logic PROGRAM_REQUEST_N,
    input wire logic PULLUP_DISABLE_SELECT,
    input wire logic [2:0] MODE_SELECT,
    input wire logic SERIAL_IN,
    output logic CONFIG_CLOCK_OUT,
    output logic CONFIG_CLOCK_OE,
    output logic SERIAL_OUT,
    output logic SERIAL_OUT_OE,
    input wire logic INIT_N_IN,
    output logic INIT_N_OUT,
    output logic INIT_N_OE,
    input wire logic DONE_IN,
    output logic DONE_OUT,
    output logic DONE_OE,
    output logic PULLUP_ENABLE,
    output logic USER_IO_RELEASE
);

    localparam logic [7:0] PROG_MIN_CNT = 8'(PROG_MIN_CYC);

    state_t st_r;
    state_t st_nxt;
    pins_t raw;
    pins_t s1_r;
    pins_t s2_r;
    logic [7:0] plo_r;
    logic restart;
    logic [31:0] cnt_r;
    logic [15:0] rx_crc_r;
    logic [15:0] crc_val;
    logic crc_ok;
    logic rise;
    logic run;
    logic sel_ref_r;
    logic [2:0] mode_r;
    logic [1:0] rate_r;
    logic [31:0] len_r;
    evt_t mask_r;
    evt_t stat_r;
    evt_t ev;
    evt_t clr;
    logic [31:0] prdata_r;
    logic [31:0] rd;
    logic wr;
    logic init_oe_r;
    logic done_oe_r;
    logic drive_r;
    logic pullup_r;
    logic release_r;
    logic dout_r;

    function automatic logic addr_hit(input logic [7:0] a);
        return a == ADDR_CTRL || a == ADDR_LEN || a == ADDR_STATUS ||
            a == ADDR_INT_STAT || a == ADDR_INT_MASK || a == ADDR_BITCNT;
    endfunction : addr_hit

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    assign raw = '{PROGRAM_REQUEST_N, PULLUP_DISABLE_SELECT,
        MODE_SELECT, SERIAL_IN, INIT_N_IN, DONE_IN};

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            s1_r <= SYNC_RST;
            s2_r <= SYNC_RST;
        end else begin
            s1_r <= raw;
            s2_r <= s1_r;
        end
    end

    // ------------------------------------------------------------
    // Program request qualification
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            plo_r <= 8'h00;
        end else if (s2_r.prog_n) begin
            plo_r <= 8'h00;
        end else if (plo_r != PROG_MIN_CNT) begin
            plo_r <= plo_r + 8'h01;
        end
    end

    assign restart = s2_r.prog_n && (plo_r == PROG_MIN_CNT);

    // ------------------------------------------------------------
    // Config clock and CRC
    // ------------------------------------------------------------
    assign run = st_r == ST_LOAD || st_r == ST_CHECK ||
        st_r == ST_PASS;

    cfg_clock_gen i_cfg_clock_gen (
        .clk(CLOCK),
        .rst(RST),
        .run(run),
        .rate(rate_r),
        .config_clock_out(CONFIG_CLOCK_OUT),
        .rise(rise)
    );

    crc16_serial i_crc16_serial (
        .clk(CLOCK),
        .rst(RST),
        .clear(st_r == ST_WAIT_INIT),
        .shift(st_r == ST_LOAD && rise),
        .bit_in(s2_r.din),
        .crc(crc_val)
    );

    assign crc_ok = {rx_crc_r[14:0], s2_r.din} == crc_val;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        unique case (st_r)
            ST_CLEAR: begin
                if (cnt_r == 32'(CLEAR_LEN - 1)) begin
                    st_nxt = ST_WAIT_INIT;
                end
            end
            ST_WAIT_INIT: begin
                if (s2_r.init_n) begin
                    st_nxt = (s2_r.mode == MODE_MASTER_SERIAL) ?
                        ST_LOAD : ST_MODE_ERR;
                end
            end
            ST_LOAD: begin
                if (rise && cnt_r + 32'h1 >= len_r) begin
                    st_nxt = ST_CHECK;
                end
            end
            ST_CHECK: begin
                if (rise && cnt_r == 32'(CRC_BITS - 1)) begin
                    st_nxt = crc_ok ? ST_PASS : ST_ERROR;
                end
            end
            ST_PASS: begin
                if (s2_r.done) begin
                    st_nxt = ST_USER;
                end
            end
            ST_USER, ST_ERROR, ST_MODE_ERR: begin
                st_nxt = st_r;
            end
        endcase
        if (restart) begin
            st_nxt = ST_CLEAR;
        end
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            st_r <= ST_CLEAR;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Cycle count in clear, bit count in load and check
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            cnt_r <= 32'h0000_0000;
        end else if (st_nxt != st_r) begin
            cnt_r <= 32'h0000_0000;
        end else if (st_r == ST_CLEAR ||
            ((st_r == ST_LOAD || st_r == ST_CHECK) && rise)) begin
            cnt_r <= cnt_r + 32'h1;
        end
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            rx_crc_r <= 16'h0000;
        end else if (st_r == ST_CHECK && rise) begin
            rx_crc_r <= {rx_crc_r[14:0], s2_r.din};
        end
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            mode_r <= 3'h0;
        end else if (st_r == ST_WAIT_INIT && s2_r.init_n) begin
            mode_r <= s2_r.mode;
        end
    end

    // Reference level of the pull-up select, taken while clearing
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            sel_ref_r <= 1'b0;
        end else if (st_r == ST_CLEAR) begin
            sel_ref_r <= s2_r.sel;
        end
    end

    // ------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            init_oe_r <= 1'b1;
            done_oe_r <= 1'b1;
            drive_r <= 1'b1;
            pullup_r <= 1'b0;
            release_r <= 1'b0;
        end else begin
            init_oe_r <= st_nxt == ST_CLEAR ||
                st_nxt == ST_ERROR;
            done_oe_r <= !(st_nxt == ST_PASS ||
                st_nxt == ST_USER);
            drive_r <= st_nxt != ST_USER;
            pullup_r <= st_nxt != ST_USER && !s2_r.sel;
            release_r <= st_nxt == ST_USER;
        end
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            dout_r <= 1'b1;
        end else if (st_r != ST_PASS) begin
            dout_r <= 1'b1;
        end else if (rise) begin
            dout_r <= s2_r.din;
        end
    end

    assign INIT_N_OUT = 1'b0;
    assign DONE_OUT = 1'b0;
    assign INIT_N_OE = init_oe_r;
    assign DONE_OE = done_oe_r;
    assign CONFIG_CLOCK_OE = drive_r;
    assign SERIAL_OUT_OE = drive_r;
    assign SERIAL_OUT = dout_r;
    assign PULLUP_ENABLE = pullup_r;
    assign USER_IO_RELEASE = release_r;

    // ------------------------------------------------------------
    // Events and interrupt
    // ------------------------------------------------------------
    assign wr = PSEL && PENABLE && PWRITE;

    always_comb begin
        ev.prog = restart;
        ev.sel_chg = (st_r == ST_WAIT_INIT || st_r == ST_LOAD ||
            st_r == ST_CHECK || st_r == ST_PASS) &&
            s2_r.sel != sel_ref_r;
        ev.mode_err = st_nxt == ST_MODE_ERR && st_r != ST_MODE_ERR;
        ev.crc_err = st_nxt == ST_ERROR && st_r != ST_ERROR;
        ev.done = st_nxt == ST_PASS && st_r != ST_PASS;
        clr = (wr && PADDR == ADDR_INT_STAT) ? evt_t'(PWDATA[4:0]) : '0;
    end

    // Set wins over a same-cycle clear
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            stat_r <= '0;
        end else begin
            stat_r <= (stat_r & ~clr) | ev;
        end
    end

    assign IRQ = |(stat_r & mask_r);

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            rate_r <= RATE_RST;
            len_r <= LEN_RST;
            mask_r <= MASK_RST;
        end else if (wr) begin
            if (PADDR == ADDR_CTRL) begin
                rate_r <= PWDATA[1:0];
            end
            if (PADDR == ADDR_LEN) begin
                len_r <= PWDATA;
            end
            if (PADDR == ADDR_INT_MASK) begin
                mask_r <= evt_t'(PWDATA[4:0]);
            end
        end
    end

    always_comb begin
        rd = 32'h0000_0000;
        unique case (PADDR)
            ADDR_CTRL: rd[1:0] = rate_r;
            ADDR_LEN: rd = len_r;
            ADDR_STATUS: begin
                rd[2:0] = st_r;
                rd[STAT_INIT_BIT] = s2_r.init_n;
                rd[STAT_DONE_BIT] = s2_r.done;
                rd[STAT_SEL_BIT] = s2_r.sel;
                rd[STAT_MODE_LSB +: 3] = mode_r;
            end
            ADDR_INT_STAT: rd[4:0] = stat_r;
            ADDR_INT_MASK: rd[4:0] = mask_r;
            ADDR_BITCNT: rd = cnt_r;
            default: rd = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            prdata_r <= 32'h0000_0000;
        end else if (PSEL && !PENABLE) begin
            prdata_r <= rd;
        end
    end

    assign PRDATA = prdata_r;
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !addr_hit(PADDR);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);

    property p_pullup;
        (st_r != ST_USER && !s2_r.sel)
            |=> PULLUP_ENABLE || USER_IO_RELEASE;
    endproperty
    a_pullup: assert property (p_pullup)
        else $error("pull-ups off during configuration");

    property p_release;
        $rose(USER_IO_RELEASE) |-> $past(s2_r.done);
    endproperty
    a_release: assert property (p_release)
        else $error("pins released before done seen high");

    property p_sel_user;
        USER_IO_RELEASE |-> !PULLUP_ENABLE && !CONFIG_CLOCK_OE;
    endproperty
    a_sel_user: assert property (p_sel_user)
        else $error("configuration drive after release");

    property p_mode;
        (st_r == ST_WAIT_INIT && s2_r.init_n && s2_r.mode != 3'h0 &&
            !restart) |=> st_r == ST_MODE_ERR;
    endproperty
    a_mode: assert property (p_mode)
        else $error("bad mode not rejected");

    property p_drive;
        (st_r == ST_LOAD || st_r == ST_CHECK) |->
            SERIAL_OUT_OE && SERIAL_OUT && CONFIG_CLOCK_OE;
    endproperty
    a_drive: assert property (p_drive)
        else $error("serial output not driven while loading");

    property p_pass;
        (st_r == ST_PASS && rise && st_nxt == ST_PASS)
            |=> SERIAL_OUT == $past(s2_r.din);
    endproperty
    a_pass: assert property (p_pass)
        else $error("pass-through bit wrong");

    property p_crc;
        (st_r == ST_CHECK && rise && !crc_ok &&
            cnt_r == 32'(CRC_BITS - 1) && !restart)
            |=> ##1 INIT_N_OE && st_r == ST_ERROR;
    endproperty
    a_crc: assert property (p_crc)
        else $error("CRC failure not flagged on init");

    property p_done;
        (st_r != ST_PASS && st_r != ST_USER) ##1
            (st_r != ST_PASS && st_r != ST_USER) |-> DONE_OE;
    endproperty
    a_done: assert property (p_done)
        else $error("done released early");

    property p_clear;
        (st_r == ST_CLEAR && $past(st_r) == ST_CLEAR) |-> INIT_N_OE;
    endproperty
    a_clear: assert property (p_clear)
        else $error("init not held low while clearing");

    property p_prog;
        restart |=> st_r == ST_CLEAR ##1 INIT_N_OE;
    endproperty
    a_prog: assert property (p_prog)
        else $error("program request did not restart");

    c_pass: cover property (st_r == ST_CHECK ##1 st_r == ST_PASS);
    c_user: cover property ($rose(USER_IO_RELEASE));
    c_crc: cover property (st_r == ST_ERROR);
    c_mode: cover property (st_r == ST_MODE_ERR);

endmodule : msc_port

// ==== sim/serial_prom_model.sv ====
`timescale 1ns/1ns
module serial_prom_model (
    input wire logic config_clock_out,
    input wire logic reset_n,
    input wire logic enable_n,
    input wire logic [31:0] image,
    output logic dout
);
    // ------------------------------------------------------------
    // Address counter, cleared while the init line is low
    // ------------------------------------------------------------
    int idx = 0;
    logic bit_now;
    always @(posedge config_clock_out or negedge reset_n) begin
        if (!reset_n) begin
            idx <= 0;
        end else begin
            idx <= idx + 1;
        end
    end
    // Past the image a toggling pattern feeds the daisy chain
    always_comb begin
        bit_now = (idx < 32) ? image[31 - idx] : idx[0];
        dout = enable_n ? ~bit_now : bit_now;
    end
endmodule : serial_prom_model

// ==== sim/msc_port_tb.sv ====
`timescale 1ns/1ns
module msc_port_tb import msc_pkg::*;;
    logic clock = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, image, rd;
    logic pready, pslverr, irq, prog_n = 1, sel = 0, sdin, hold = 1;
    logic [2:0] mode = 3'h0;
    logic config_clock_out, config_clock_out_oe, sout, sout_oe, init_oe, done_oe, pu, rel;
    logic init_in, done_in, init_out, done_out, err;
    int error_cnt = 0, cmp_count = 0;
    time t0;
    always #5 clock = ~clock;
    // Open-drain lines with pull-ups; the PROM may hold init low
    assign init_in = !hold && (init_oe ? init_out : 1'b1);
    assign done_in = done_oe ? done_out : 1'b1;
    msc_port #(.CLEAR_LEN(4)) i_msc_port (.CLOCK(clock), .RST(rst),
        .PADDR(paddr), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .IRQ(irq), .PROGRAM_REQUEST_N(prog_n),
        .PULLUP_DISABLE_SELECT(sel), .MODE_SELECT(mode),
        .SERIAL_IN(sdin), .CONFIG_CLOCK_OUT(config_clock_out),
        .CONFIG_CLOCK_OE(config_clock_out_oe), .SERIAL_OUT(sout),
        .SERIAL_OUT_OE(sout_oe), .INIT_N_IN(init_in),
        .INIT_N_OUT(init_out),
        .INIT_N_OE(init_oe), .DONE_IN(done_in), .DONE_OUT(done_out),
        .DONE_OE(done_oe), .PULLUP_ENABLE(pu), .USER_IO_RELEASE(rel));
    serial_prom_model i_serial_prom_model (.config_clock_out(config_clock_out),
        .reset_n(init_in), .enable_n(done_in), .image(image),
        .dout(sdin));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task end_sim;
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_sim
    task check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : apb
    task wait_state(input logic [2:0] st);
        int n;
        n = 0;
        do begin
            apb(0, ADDR_STATUS, 32'h0);
            n++;
        end while (rd[2:0] !== st && n < 3000);
        check(rd[2:0], st);
    endtask : wait_state
    task restart(input int len);
        @(posedge clock);
        prog_n <= 0;
        repeat (len) @(posedge clock);
        prog_n <= 1;
    endtask : restart
    task half_period(input int exp);
        @(posedge config_clock_out);
        t0 = $time;
        @(negedge config_clock_out);
        check($time - t0, exp);
    endtask : half_period
    function automatic logic [31:0] make_image(input logic [15:0] d);
        logic [15:0] c;
        c = 16'hFFFF;
        for (int i = 15; i >= 0; i--) begin
            c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? 16'h1021 : 16'h0);
        end
        return {d, c};
    endfunction : make_image
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        #200_000;
        error_cnt++;
        end_sim();
    end
    initial begin
        image = make_image(16'hA5C3);
        repeat (2) @(posedge clock);
        rst <= 0;
        repeat (2) @(posedge clock);
        @(negedge clock);
        check(pu, 1);
        check(init_oe, 1);
        check(done_oe, 1);
        check(rel, 0);
        apb(1, ADDR_LEN, 32'h10);
        apb(1, ADDR_INT_MASK, 32'h1F);
        apb(0, ADDR_LEN, 32'h0);
        check(rd, 32'h10);
        check(err, 0);
        apb(0, ADDR_CTRL, 32'h0);
        check(rd, 32'h0);
        apb(0, 8'h18, 32'h0);
        check(rd, 32'h0);
        check(err, 1);
        hold <= 0;
        wait_state(3'h2);
        check({config_clock_out_oe, sout_oe, sout}, 3'h7);
        half_period(40);
        wait_state(3'h5);
        check(rd[10:8], 3'h0);
        check({rel, pu, done_oe}, 3'h4);
        check(irq, 1);
        apb(0, ADDR_INT_STAT, 32'h0);
        check(rd, 32'h1);
        apb(1, ADDR_INT_STAT, 32'h1F);
        @(negedge clock);
        check(irq, 0);
        // Select changes here between configurations
        sel <= 1;
        apb(1, ADDR_CTRL, 32'h1);
        image = make_image(16'hA5C3) ^ 32'h1;
        restart(60);
        wait_state(3'h2);
        half_period(80);
        check(pu, 0);
        // Select moved in mid-load must raise its event
        sel <= 0;
        wait_state(3'h6);
        check({init_oe, done_oe, rel}, 3'h6);
        apb(0, ADDR_INT_STAT, 32'h0);
        check(rd, 32'h1A);
        apb(1, ADDR_INT_STAT, 32'h1F);
        sel <= 1;
        mode <= 3'h1;
        image = make_image(16'hA5C3);
        restart(60);
        wait_state(3'h7);
        check(rd[10:8], 3'h1);
        check(done_oe, 1);
        apb(0, ADDR_INT_STAT, 32'h0);
        check(rd, 32'h14);
        restart(10);
        repeat (20) @(posedge clock);
        wait_state(3'h7);
        end_sim();
    end
endmodule : msc_port_tb
